// >>> core/sfp_arm_window.sv
`timescale 1ns/100ps
// ****************************************************
// Arming window counter, started by the arming write.
// ****************************************************
module sfp_arm_window
  import sfp_pkg::*;
#(
  parameter logic [2:0] LIMIT = SPM_WINDOW_CYC
)(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Control.
  input wire logic start_in,
  input wire logic stop_in,
  // Status.
  output logic active_out,
  output logic [SFP_CNT_W-1:0] count_out,
  output logic expire_out
);

  logic act_r; // Window open.
  logic act_nxt;
  logic [SFP_CNT_W-1:0] cnt_r; // Cycles since arming.
  logic [SFP_CNT_W-1:0] cnt_nxt;

  // A restart wins over stop so a rewrite reopens the window.
  always_comb
  begin
    act_nxt = act_r;
    cnt_nxt = cnt_r;
    if (start_in)
    begin
      act_nxt = 1'b1;
      cnt_nxt = '0;
    end
    else if (stop_in || expire_out)
    begin
      act_nxt = 1'b0;
      cnt_nxt = '0;
    end
    else if (act_r)
    begin
      cnt_nxt = cnt_r + 3'h1;
    end
  end

  // Registers only.
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      act_r <= 1'b0;
      cnt_r <= '0;
    end
    else
    begin
      act_r <= act_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign active_out = act_r;
  assign count_out = cnt_r;
  assign expire_out = act_r && (cnt_r == LIMIT - 3'h1);

endmodule : sfp_arm_window

// >>> core/sfp_pkg.sv
package sfp_pkg;

  // ****************************************************
  // Register map and field positions.
  // ****************************************************
  localparam logic [5:0] SFP_CTRL_ADDR = 6'h37; // I/O address.
  localparam logic [7:0] SFP_CTRL_RESET = 8'h00;
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_RWW_BUSY = 6;
  localparam int BIT_RSVD = 5;
  localparam int BIT_RWW_SRE = 4;
  localparam int BIT_LOCK_RD = 3;
  localparam int BIT_PG_WR = 2;
  localparam int BIT_PG_ER = 1;
  localparam int BIT_EN = 0;

  // Only these low-five-bit patterns act when written.
  localparam logic [4:0] PAT_RWW_SRE = 5'h11;
  localparam logic [4:0] PAT_LOCK_RD = 5'h09;
  localparam logic [4:0] PAT_PG_WR = 5'h05;
  localparam logic [4:0] PAT_PG_ER = 5'h03;
  localparam logic [4:0] PAT_BUF_FILL = 5'h01;

  // ****************************************************
  // Timing counts, in CPU clock cycles.
  // ****************************************************
  localparam int SFP_CNT_W = 3;
  localparam logic [2:0] SPM_WINDOW_CYC = 3'h4;
  localparam logic [2:0] LPM_WINDOW_CYC = 3'h3;

  // ****************************************************
  // Types.
  // ****************************************************
  typedef enum logic [1:0] {SFP_IDLE, SFP_ARMED, SFP_BUSY} sfp_state_type;

  // Stored control and status bits.
  typedef struct packed {
    logic irq_en;
    logic rww_busy;
    logic rww_sre;
    logic lock_read;
    logic page_write;
    logic page_erase;
    logic enable;
  } sfp_ctrl_type;

  // One-cycle commands towards the flash array.
  typedef struct packed {
    logic erase;
    logic write;
    logic buf_wr;
    logic buf_clear;
  } sfp_flash_cmd_type;

  // Builds the register read image; bit 5 always reads zero.
  function automatic logic [7:0] sfp_pack(input sfp_ctrl_type c,
                                          input logic rww_ok);
    logic [7:0] v;
    v = 8'h00;
    v[BIT_IRQ_EN] = c.irq_en;
    v[BIT_RWW_BUSY] = c.rww_busy & rww_ok;
    v[BIT_RWW_SRE] = c.rww_sre;
    v[BIT_LOCK_RD] = c.lock_read;
    v[BIT_PG_WR] = c.page_write;
    v[BIT_PG_ER] = c.page_erase;
    v[BIT_EN] = c.enable;
    return v;
  endfunction : sfp_pack

endpackage : sfp_pkg

// >>> core/sfp_self_program.sv
`timescale 1ns/100ps
// Overview of operation
// - Ready irq needs enable, global flag, clear enable.
// - No ready irq during EEPROM write or programming.
// - Without READ_WHILE_WRITE_SECTION support busy bit reads zero.
// - Reserved bit always reads zero.
// - Read-enable write while filling clears buffer.
// - Load within three cycles returns lock/fuse.
// - Page write programs buffer into addressed page.
// - Page-write bit clears on finish or timeout.
// - Page erase erases the addressed page.
// - Page-erase bit clears on finish or timeout.
// - Enable opens four-cycle store window, then clears.
// - Plain enable stores register pair in buffer.
// - Enable stays high until erase/write completes.
// - Only five low-bit patterns act.
// - Store acts only from boot loader section.
// - Boot store may target any page.
// - Boot-size fuses set section boundary.
// - READ_WHILE_WRITE_SECTION page programming keeps CPU running.
// - NO_READ_WHILE_WRITE_SECTION page programming halts the CPU.
// - Busy bit set while READ_WHILE_WRITE_SECTION blocked; software clears.
// - Boot section lies wholly inside NO_READ_WHILE_WRITE_SECTION.
// - Fuse bits read zero when programmed.
module sfp_self_program
  import sfp_pkg::*;
#(
  parameter int PAGE_BITS = 7,
  parameter int WORD_BITS = 6,
  parameter int NO_READ_WHILE_WRITE_SECTION_PAGES = 32,
  parameter int BOOT_MIN_PAGES = 4,
  parameter bit RWW_SUPPORT = 1'b1
)(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // CPU I/O register port.
  input wire logic [5:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  // CPU instruction strobes and operands.
  input wire logic spm_exec_in,
  input wire logic lpm_exec_in,
  input wire logic [PAGE_BITS+WORD_BITS-1:0] exec_pc_in,
  input wire logic [15:0] z_ptr_in,
  input wire logic [15:0] r1r0_data_in,
  input wire logic global_irq_en_in,
  input wire logic eeprom_busy_in,
  // Fuse and lock values, zero means programmed.
  input wire logic [1:0] boot_size_fuses_in,
  input wire logic [7:0] lock_bits_in,
  input wire logic [7:0] fuse_bits_in,
  // Flash array side.
  input wire logic flash_busy_in,
  input wire logic flash_done_in,
  output sfp_flash_cmd_type flash_cmd_out,
  output logic [PAGE_BITS-1:0] flash_page_out,
  output logic [WORD_BITS-1:0] buf_word_out,
  output logic [15:0] buf_data_out,
  // Results towards the CPU.
  output logic lpm_override_out,
  output logic [7:0] lpm_data_out,
  output logic cpu_halt_out,
  output logic ready_irq_out
);

  // ****************************************************
  // Constants derived from parameters.
  // ****************************************************
  localparam int PW = PAGE_BITS + 1;
  localparam logic [PW-1:0] TOTAL_PAGES = PW'(1 << PAGE_BITS);
  localparam logic [PW-1:0] NO_READ_WHILE_WRITE_SECTION_START = TOTAL_PAGES - PW'(NO_READ_WHILE_WRITE_SECTION_PAGES);

  // ****************************************************
  // State.
  // ****************************************************
  sfp_state_type state_r; // Sequencer state.
  sfp_state_type state_nxt;
  sfp_ctrl_type ctrl_r; // Control register bits.
  sfp_ctrl_type ctrl_nxt;
  logic dirty_r; // Temporary buffer is being filled.
  logic dirty_nxt;
  logic [PW-1:0] boot_start_r; // First boot loader page.
  logic [PW-1:0] boot_start_nxt;
  logic [PW-1:0] boot_pages; // Boot section size.
  sfp_flash_cmd_type cmd_nxt;
  logic [PAGE_BITS-1:0] page_nxt;
  logic [WORD_BITS-1:0] word_nxt;
  logic [15:0] data_nxt;
  logic lpm_ovr_nxt;
  logic [7:0] lpm_data_nxt;
  logic halt_nxt;
  logic irq_nxt;
  logic [7:0] rdata_nxt;
  // Window counter hookup.
  logic win_start;
  logic win_stop;
  logic win_active;
  logic [SFP_CNT_W-1:0] win_cnt;
  logic win_expire;
  // Decoded strobes.
  logic reg_wr;
  logic pat_ok;
  logic in_boot;
  logic spm_ok;
  logic lpm_ok;
  logic [PAGE_BITS-1:0] z_page;
  logic tgt_no_read_while_write_section;

  // The window opens at the register write itself.
  sfp_arm_window #(
    .LIMIT(SPM_WINDOW_CYC)
  ) u_window (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .start_in(win_start),
    .stop_in(win_stop),
    .active_out(win_active),
    .count_out(win_cnt),
    .expire_out(win_expire)
  );

  // ****************************************************
  // Decode.
  // ****************************************************
  // Fuses encode size; the clamp keeps boot inside NO_READ_WHILE_WRITE_SECTION.
  always_comb
  begin
    boot_pages = PW'(BOOT_MIN_PAGES) << (~boot_size_fuses_in);
    if (boot_pages > PW'(NO_READ_WHILE_WRITE_SECTION_PAGES))
    begin
      boot_pages = PW'(NO_READ_WHILE_WRITE_SECTION_PAGES);
    end
    boot_start_nxt = TOTAL_PAGES - boot_pages;
  end

  assign reg_wr = io_wr_in && (io_addr_in == SFP_CTRL_ADDR);
  assign pat_ok = (io_wdata_in[4:0] == PAT_RWW_SRE) ||
                  (io_wdata_in[4:0] == PAT_LOCK_RD) ||
                  (io_wdata_in[4:0] == PAT_PG_WR) ||
                  (io_wdata_in[4:0] == PAT_PG_ER) ||
                  (io_wdata_in[4:0] == PAT_BUF_FILL);
  assign in_boot = {1'b0, exec_pc_in[PAGE_BITS+WORD_BITS-1:WORD_BITS]}
                   >= boot_start_r;
  // An EEPROM write blocks all self-programming.
  assign spm_ok = (state_r == SFP_ARMED) && win_active && spm_exec_in &&
                  in_boot && !eeprom_busy_in;
  assign lpm_ok = (state_r == SFP_ARMED) && ctrl_r.lock_read &&
                  lpm_exec_in && (win_cnt < LPM_WINDOW_CYC) &&
                  !eeprom_busy_in;
  // Any page may be targeted, the boot section included.
  assign z_page = z_ptr_in[WORD_BITS+PAGE_BITS:WORD_BITS+1];
  assign tgt_no_read_while_write_section = {1'b0, z_page} >= NO_READ_WHILE_WRITE_SECTION_START;

  // ****************************************************
  // Sequencer next state.
  // ****************************************************
  always_comb
  begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    dirty_nxt = dirty_r;
    cmd_nxt = '0;
    page_nxt = flash_page_out;
    word_nxt = buf_word_out;
    data_nxt = buf_data_out;
    lpm_ovr_nxt = 1'b0;
    lpm_data_nxt = lpm_data_out;
    halt_nxt = cpu_halt_out;
    win_start = 1'b0;
    win_stop = 1'b0;
    case (state_r)
      SFP_IDLE, SFP_ARMED:
      begin
        if (reg_wr)
        begin
          ctrl_nxt.irq_en = io_wdata_in[BIT_IRQ_EN];
          if (pat_ok)
          begin
            // Arming: one command bit with enable, or enable alone.
            ctrl_nxt.rww_sre = io_wdata_in[BIT_RWW_SRE];
            ctrl_nxt.lock_read = io_wdata_in[BIT_LOCK_RD];
            ctrl_nxt.page_write = io_wdata_in[BIT_PG_WR];
            ctrl_nxt.page_erase = io_wdata_in[BIT_PG_ER];
            ctrl_nxt.enable = 1'b1;
            state_nxt = SFP_ARMED;
            win_start = 1'b1;
            if (io_wdata_in[BIT_RWW_SRE] && dirty_r)
            begin
              // Half-filled data would be stale, so it is dropped.
              cmd_nxt.buf_clear = 1'b1;
              dirty_nxt = 1'b0;
            end
          end
        end
        else if (spm_ok)
        begin
          win_stop = 1'b1;
          if (ctrl_r.page_erase || ctrl_r.page_write)
          begin
            // Register pair data is ignored for page operations.
            cmd_nxt.erase = ctrl_r.page_erase;
            cmd_nxt.write = ctrl_r.page_write;
            page_nxt = z_page;
            if (ctrl_r.page_write)
            begin
              dirty_nxt = 1'b0;
            end
            halt_nxt = tgt_no_read_while_write_section;
            ctrl_nxt.rww_busy = RWW_SUPPORT && !tgt_no_read_while_write_section;
            state_nxt = SFP_BUSY;
          end
          else
          begin
            if (ctrl_r.rww_sre && !flash_busy_in)
            begin
              ctrl_nxt.rww_busy = 1'b0;
            end
            else if (!ctrl_r.rww_sre && !ctrl_r.lock_read)
            begin
              // Pointer bit zero is ignored for buffer words.
              cmd_nxt.buf_wr = 1'b1;
              word_nxt = z_ptr_in[WORD_BITS:1];
              data_nxt = r1r0_data_in;
              dirty_nxt = 1'b1;
            end
            ctrl_nxt.rww_sre = 1'b0;
            ctrl_nxt.lock_read = 1'b0;
            ctrl_nxt.enable = 1'b0;
            state_nxt = SFP_IDLE;
          end
        end
        else if (lpm_ok)
        begin
          // Pointer bit zero set selects lock bits, else fuses.
          lpm_ovr_nxt = 1'b1;
          lpm_data_nxt = z_ptr_in[0] ? lock_bits_in
                                     : fuse_bits_in;
          ctrl_nxt.lock_read = 1'b0;
          ctrl_nxt.enable = 1'b0;
          win_stop = 1'b1;
          state_nxt = SFP_IDLE;
        end
        else if ((state_r == SFP_ARMED) && win_expire)
        begin
          // Unused window: every command bit drops with enable.
          ctrl_nxt.rww_sre = 1'b0;
          ctrl_nxt.lock_read = 1'b0;
          ctrl_nxt.page_write = 1'b0;
          ctrl_nxt.page_erase = 1'b0;
          ctrl_nxt.enable = 1'b0;
          state_nxt = SFP_IDLE;
        end
      end
      SFP_BUSY:
      begin
        // Writes are ignored here except the interrupt enable.
        if (reg_wr)
        begin
          ctrl_nxt.irq_en = io_wdata_in[BIT_IRQ_EN];
        end
        if (flash_done_in)
        begin
          ctrl_nxt.page_write = 1'b0;
          ctrl_nxt.page_erase = 1'b0;
          ctrl_nxt.enable = 1'b0;
          halt_nxt = 1'b0;
          state_nxt = SFP_IDLE;
        end
      end
      default:
      begin
        state_nxt = SFP_IDLE;
      end
    endcase
  end

  // Ready interrupt and registered read data.
  always_comb
  begin
    irq_nxt = ctrl_r.irq_en && global_irq_en_in && !ctrl_r.enable &&
              !eeprom_busy_in && (state_r != SFP_BUSY);
    rdata_nxt = 8'h00;
    if (io_rd_in && (io_addr_in == SFP_CTRL_ADDR))
    begin
      rdata_nxt = sfp_pack(ctrl_r, RWW_SUPPORT);
    end
  end

  // ****************************************************
  // Registers.
  // ****************************************************
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      state_r <= SFP_IDLE;
      ctrl_r <= sfp_ctrl_type'(SFP_CTRL_RESET[6:0]);
      dirty_r <= 1'b0;
      boot_start_r <= '0;
      flash_cmd_out <= '0;
      flash_page_out <= '0;
      buf_word_out <= '0;
      buf_data_out <= 16'h0000;
      lpm_override_out <= 1'b0;
      lpm_data_out <= 8'h00;
      cpu_halt_out <= 1'b0;
      ready_irq_out <= 1'b0;
      io_rdata_out <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      dirty_r <= dirty_nxt;
      boot_start_r <= boot_start_nxt;
      flash_cmd_out <= cmd_nxt;
      flash_page_out <= page_nxt;
      buf_word_out <= word_nxt;
      buf_data_out <= data_nxt;
      lpm_override_out <= lpm_ovr_nxt;
      lpm_data_out <= lpm_data_nxt;
      cpu_halt_out <= halt_nxt;
      ready_irq_out <= irq_nxt;
      io_rdata_out <= rdata_nxt;
    end
  end

  // ****************************************************
  // Assertions.
  // ****************************************************
  sequence arm_write_s;
    reg_wr && pat_ok && (state_r != SFP_BUSY);
  endsequence

  sequence quiet4_s;
    (!spm_exec_in && !lpm_exec_in && !io_wr_in)[*4];
  endsequence

  AST_IRQ_GATE: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    !(ctrl_r.irq_en && global_irq_en_in && !ctrl_r.enable) |=>
      !ready_irq_out)
    else $error("Ready interrupt raised without its conditions.");

  AST_IRQ_QUIET: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    (eeprom_busy_in || state_r == SFP_BUSY) |=> !ready_irq_out)
    else $error("Ready interrupt during a write operation.");

  AST_RSVD_ZERO: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    !io_rdata_out[BIT_RSVD])
    else $error("Reserved bit read as one.");

  AST_RWW_ZERO: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    !RWW_SUPPORT |-> !io_rdata_out[BIT_RWW_BUSY])
    else $error("Busy bit set on a variant without support.");

  AST_WIN_EXPIRE: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    arm_write_s ##1 quiet4_s |=> !ctrl_r.enable && !ctrl_r.page_write)
    else $error("Enable outlived the four-cycle window.");

  AST_BUSY_HOLD: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    (state_r == SFP_BUSY) |-> ctrl_r.enable)
    else $error("Enable dropped before the operation ended.");

  AST_APP_INERT: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    (state_r == SFP_ARMED && spm_exec_in && !in_boot && !reg_wr) |=>
      (flash_cmd_out == '0))
    else $error("Store from application section acted.");

  AST_BUF_CLEAR: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    (arm_write_s ##0 (io_wdata_in[BIT_RWW_SRE] && dirty_r)) |=>
      flash_cmd_out.buf_clear && !dirty_r)
    else $error("Buffer not cleared by read-enable write.");

  AST_NO_READ_WHILE_WRITE_SECTION_HALT: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    (spm_ok && !reg_wr && (ctrl_r.page_erase || ctrl_r.page_write))
      |=> (cpu_halt_out == $past(tgt_no_read_while_write_section)) && (state_r == SFP_BUSY))
    else $error("Halt does not follow the target section.");

endmodule : sfp_self_program

// >>> tb/sfp_flash_model.sv
`timescale 1ns/100ps
// ****************************************************
// Behavioural flash array behind the sequencer.
// ****************************************************
module sfp_flash_model
  import sfp_pkg::*;
#(
  parameter int LAT = 12
)(
  // Clock.
  input wire logic sys_clk_in,
  // Commands and buffer data from the sequencer.
  input wire sfp_flash_cmd_type cmd_in,
  input wire logic [5:0] word_in,
  input wire logic [15:0] data_in,
  // Status towards the sequencer.
  output logic busy_out,
  output logic done_out
);
  // Buffer words in arrival order, word above data.
  logic [21:0] fill_q[$];
  // Cycles left in the running page operation.
  int left = 0;

  initial
  begin
    busy_out = 1'b0;
    done_out = 1'b0;
  end

  // A page op stays busy a fixed time, then pulses done once.
  // The time is short on purpose so the run stays brief.
  always @(posedge sys_clk_in)
  begin
    done_out <= 1'b0;
    if (cmd_in.erase | cmd_in.write)
    begin
      left = LAT;
      busy_out <= 1'b1;
    end
    else if (left == 1)
    begin
      left = 0;
      busy_out <= 1'b0;
      done_out <= 1'b1;
    end
    else if (left > 1)
      left = left - 1;
    // Clearing drops every word filled so far.
    if (cmd_in.buf_clear)
      fill_q.delete();
    if (cmd_in.buf_wr)
      fill_q.push_back({word_in, data_in});
  end
endmodule : sfp_flash_model

// >>> tb/test_flash_self_program_control.sv
`timescale 1ns/100ps
// ****************************************************
// Self-checking bench for the self-programming block.
// ****************************************************
module test_flash_self_program_control;
  import sfp_pkg::*;
  // Boot page 124 and application page 1, as word addresses.
  localparam logic [12:0] BOOT_PC = 13'h1F00;
  localparam logic [12:0] APP_PC = 13'h0040;
  logic sys_clk = 1'b0, rst_b = 1'b0;
  logic [5:0] io_addr = SFP_CTRL_ADDR;
  logic io_wr = 1'b0, io_rd = 1'b0, spm = 1'b0, lpm = 1'b0;
  logic gie = 1'b0, eeb = 1'b0, fbusy, fdone, ovr, halt, irq;
  logic [7:0] io_wdata = 8'h00, rdata, lockb = 8'h00, fuseb = 8'h00;
  logic [7:0] ldata, lcap, v;
  logic [12:0] pc = 13'h0000;
  logic [1:0] bsz = 2'b11; // Boot-size fuses, 11 is the smallest section.
  logic [15:0] z = 16'h0000, r1r0 = 16'h0000, bdata;
  logic [6:0] page;
  logic [5:0] word;
  sfp_flash_cmd_type cmd;
  logic [31:0] seed = 32'd27158;
  logic [21:0] exp_q[$];
  int n_errors = 0, samples_checked = 0, n_er = 0, n_wr = 0, n_ovr = 0;
  int cyc = 0;

  always #5 sys_clk = ~sys_clk;

  sfp_self_program dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
    .io_addr_in(io_addr), .io_wr_in(io_wr), .io_rd_in(io_rd),
    .io_wdata_in(io_wdata), .io_rdata_out(rdata), .spm_exec_in(spm),
    .lpm_exec_in(lpm), .exec_pc_in(pc), .z_ptr_in(z),
    .r1r0_data_in(r1r0), .global_irq_en_in(gie), .eeprom_busy_in(eeb),
    .boot_size_fuses_in(bsz), .lock_bits_in(lockb),
    .fuse_bits_in(fuseb), .flash_busy_in(fbusy),
    .flash_done_in(fdone), .flash_cmd_out(cmd), .flash_page_out(page),
    .buf_word_out(word), .buf_data_out(bdata),
    .lpm_override_out(ovr), .lpm_data_out(ldata), .cpu_halt_out(halt),
    .ready_irq_out(irq));

  sfp_flash_model u_flash (.sys_clk_in(sys_clk), .cmd_in(cmd),
    .word_in(word), .data_in(bdata), .busy_out(fbusy),
    .done_out(fdone));

  // ****************************************************
  // Monitor and helpers.
  // ****************************************************
  // Pulses are counted mid-cycle so no edge race can hide them.
  always @(negedge sys_clk)
  begin
    if (cmd.erase === 1'b1) n_er++;
    if (cmd.write === 1'b1) n_wr++;
    if (ovr === 1'b1)
    begin
      n_ovr++;
      lcap = ldata;
    end
  end

  // A hang is cut short and counted as a mismatch.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Register write; returns at the edge that takes it.
  task automatic wr(input logic [7:0] d);
    @(posedge sys_clk);
    io_addr <= SFP_CTRL_ADDR;
    io_wr <= 1'b1;
    io_wdata <= d;
    @(posedge sys_clk);
    io_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    io_addr <= SFP_CTRL_ADDR;
    @(negedge sys_clk);
    chk(32'(rdata), 32'(e));
  endtask : rd

  // Store or load one cycle after the arming write.
  task automatic exec(input logic ld, input logic [12:0] p,
                      input logic [15:0] zz, input logic [15:0] d);
    spm <= ~ld;
    lpm <= ld;
    pc <= p;
    z <= zz;
    r1r0 <= d;
    @(posedge sys_clk);
    spm <= 1'b0;
    lpm <= 1'b0;
    // The second edge lets the monitor count the pulse first.
    repeat (2) @(negedge sys_clk);
  endtask : exec

  task automatic wait_done();
    for (int i = 0; i < 100 && fdone !== 1'b1; i++)
      @(negedge sys_clk);
    @(negedge sys_clk);
  endtask : wait_done

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // ****************************************************
  // Main sequence.
  // ****************************************************
  initial
  begin
    logic [15:0] zz, d;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(SFP_CTRL_ADDR, 8'h00);
    rd(6'h36, 8'h00);
    // Back-to-back buffer fills with random pointer and data.
    for (int i = 0; i < 3; i++)
    begin
      zz = 16'(rnd());
      d = 16'(rnd());
      wr(8'h01);
      exec(1'b0, BOOT_PC, zz, d);
      exp_q.push_back({zz[6:1], d});
    end
    repeat (2) @(negedge sys_clk);
    chk(u_flash.fill_q.size(), 3);
    for (int i = 0; i < 3; i++)
      chk(32'(u_flash.fill_q[i]), 32'(exp_q[i]));
    rd(SFP_CTRL_ADDR, 8'h00);
    wr(8'h11);
    repeat (6) @(negedge sys_clk);
    chk(u_flash.fill_q.size(), 0);
    rd(SFP_CTRL_ADDR, 8'h00);
    // A store from the application section does nothing.
    wr(8'h01);
    exec(1'b0, APP_PC, 16'h0002, 16'h1234);
    repeat (6) @(negedge sys_clk);
    chk(u_flash.fill_q.size(), 0);
    // Page 100 is application code until the boot section grows.
    wr(8'h01);
    exec(1'b0, 13'h1900, 16'h0002, 16'h1234);
    @(posedge sys_clk);
    bsz <= 2'b00;
    wr(8'h01);
    exec(1'b0, 13'h1900, 16'h0002, 16'h1234);
    repeat (2) @(negedge sys_clk);
    chk(u_flash.fill_q.size(), 1);
    // Page commands left without a store expire.
    wr(8'h05);
    repeat (6) @(negedge sys_clk);
    rd(SFP_CTRL_ADDR, 8'h00);
    wr(8'h03);
    repeat (6) @(negedge sys_clk);
    rd(SFP_CTRL_ADDR, 8'h00);
    chk(n_er + n_wr, 0);
    // Erase of page 100, which halts the CPU.
    wr(8'h03);
    exec(1'b0, BOOT_PC, 16'h3200, 16'hFFFF);
    chk(n_er, 1);
    chk(32'({page, halt}), 32'({7'h64, 1'b1}));
    rd(SFP_CTRL_ADDR, 8'h03);
    wait_done();
    chk(32'(halt), 0);
    rd(SFP_CTRL_ADDR, 8'h00);
    // Write of page 5, so the CPU keeps running.
    wr(8'h05);
    exec(1'b0, BOOT_PC, 16'h0280, 16'hFFFF);
    chk(n_wr, 1);
    chk(32'({page, halt}), 32'({7'h05, 1'b0}));
    wait_done();
    rd(SFP_CTRL_ADDR, 8'h40);
    wr(8'h11);
    exec(1'b0, BOOT_PC, 16'h0000, 16'h0000);
    rd(SFP_CTRL_ADDR, 8'h00);
    // Lock and fuse reads select on pointer bit zero.
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk);
      lockb <= 8'(rnd());
      fuseb <= 8'(rnd());
      wr(8'h09);
      exec(1'b1, BOOT_PC, 16'(i), 16'h0000);
      chk(n_ovr, i + 1);
      chk(32'(lcap), 32'(i ? lockb : fuseb));
    end
    // Other patterns keep only the interrupt enable.
    for (int i = 0; i < 6; i++)
    begin
      v = 8'(rnd());
      if (v[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01})
        v[0] = 1'b0;
      wr(v);
      rd(SFP_CTRL_ADDR, {v[7], 7'h00});
    end
    // Ready interrupt gating.
    wr(8'h80);
    @(posedge sys_clk);
    gie <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(32'(irq), 1);
    @(posedge sys_clk);
    eeb <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(32'(irq), 0);
    @(posedge sys_clk);
    eeb <= 1'b0;
    gie <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(32'(irq), 0);
    @(posedge sys_clk);
    gie <= 1'b1;
    wr(8'h81);
    repeat (2) @(negedge sys_clk);
    chk(32'(irq), 0);
    wr(8'h00);
    repeat (4) @(negedge sys_clk);
    final_report();
  end
endmodule : test_flash_self_program_control
